/* File: hdl/legacy_vm_mode_control.sv */
// Legacy VM mode control: privilege checks and interrupt dispatch choice
// Notes on behaviour
// RULE1: Leave mode on suspend, switch, or interrupt
// RULE2: Task switch reloads flags; clears mode flag (the code keeps it for a 32-bit image that has it set)
// RULE3: Then protected addressing, 32-bit protected execution
// RULE4: Six instructions sensitive to I/O privilege
// RULE5: Port I/O instructions skip privilege check
// RULE6: Privilege held at 3; low IO_PRIVILEGE_LEVEL faults
// RULE7: Port access decided by permission map only (the code faults every port above 1023 without reading the map)
// RULE8: Not-present page access raises page fault
// RULE9: Interrupts and exceptions make implicit handler call
// RULE10: Extension enable is control four bit 0
// RULE11: I/O privilege from flags bits 12-13
// RULE12: 256-bit redirection map, one per vector
// RULE13: Hardware interrupts, exceptions go to protected
// RULE14: Extension clear: no redirection, no virtual
// RULE15: Extension set: redirection and virtual interrupts
// RULE16: Six dispatch methods from three inputs
// RULE17: Redirection bit 0 legacy, 1 protected
// RULE18: Redirection map sits 32 bytes below map
// RULE19: Protected entry clears flags, pushes, zeroes segments
// RULE20: Legacy entry pushes flags, vector table, clears IF
// RULE21: Fault raised before any state change
`default_nettype none
module legacy_vm_mode_control
   import vm_ctrl_pkg::*;
(
   input  wire logic                      mclk_i,
   input  wire logic                      rst_i,
   input  wire vm_ctrl_pkg::apb_req_type  apb_i,
   output vm_ctrl_pkg::apb_rsp_type       apb_o,
   output logic                           legacy_mode_o,
   output logic      [1:0]                cpl_o,
   output vm_ctrl_pkg::result_type        result_o,
   output logic      [31:0]               flags_o,
   output logic      [31:0]               push_flags_o,
   output logic      [31:0]               code_ptr_o,
   output logic                           seg_clear_o
);
   import vm_ctrl_pkg::*;

   typedef enum {ST_IDLE, ST_LOOKUP, ST_DECIDE} state_type;

   logic [31:0] ctrl_q;
   logic [31:0] flags_q;
   logic [31:0] req_q;
   logic [15:0] iomap_q;
   state_type   state_q;
   result_type  result_q;
   logic [31:0] push_flags_q;
   logic [31:0] code_ptr_q;
   logic        seg_clear_q;
   logic [1:0]  cpl_q;
   logic        busy_q;
   apb_rsp_type rsp_q;
   logic        wr_acc;
   logic        rd_acc;
   logic        start;
   op_type      op;
   logic [7:0]  vec;
   logic [15:0] port;
   logic        pg_present;
   logic        mee;
   logic [1:0]  io_privilege_level;
   logic        redir_bit;
   logic        perm_bit;
   logic [31:0] redir_word;
   logic [31:0] perm_word;
   logic        redir_we;
   logic        perm_we;
   logic [15:0] gp_count;
   logic        sensitive;
   logic        port_op;
   logic        sw_int;
   result_type  res_d;
   logic [31:0] sel_word;

   assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite;
   assign rd_acc = apb_i.psel && apb_i.penable && !apb_i.pwrite;
   assign start  = wr_acc && apb_i.paddr == ADDR_REQ && !busy_q;
   assign op     = op_type'(req_q[3:0]);
   assign vec    = req_q[15:8];
   assign port   = req_q[31:16];
   assign pg_present = req_q[4];
   assign mee    = ctrl_q[MEE_BIT];                       // see RULE10
   assign io_privilege_level   = flags_q[IO_PRIVILEGE_LEVEL_LO +: 2];                 // see RULE11
   // Redirection map sits directly below the permission map
   assign redir_we = wr_acc && apb_i.paddr >= ADDR_PERM - REDIR_BYTES
                     && apb_i.paddr < ADDR_PERM;       // see RULE18
   assign perm_we  = wr_acc && apb_i.paddr >= ADDR_PERM
                     && apb_i.paddr < ADDR_PERM + 4 * PERM_WORDS;

   // Redirection map: one flag per software vector
   vm_bitmap_mem #(.WORDS(REDIR_WORDS), .AW(3)) u_redir (  // see RULE12
      .mclk_i  (mclk_i),
      .we_i    (redir_we),
      .waddr_i (apb_i.paddr[4:2]),
      .wdata_i (apb_i.pwdata),
      .raddr_i (vec[7:5]),
      .rdata_o (redir_word)
   );

   // Port permission map for the first 1024 ports
   vm_bitmap_mem #(.WORDS(PERM_WORDS), .AW(5)) u_perm (
      .mclk_i  (mclk_i),
      .we_i    (perm_we),
      // Window starts at word 16: flipping bit 6 gives the map index
      .waddr_i ({~apb_i.paddr[6], apb_i.paddr[5:2]}),
      .wdata_i (apb_i.pwdata),
      .raddr_i (port[9:5]),
      .rdata_o (perm_word)
   );

   vm_event_cnt #(.W(16)) u_gp_cnt (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .clr_i   (wr_acc && apb_i.paddr == ADDR_STATUS),
      .inc_i   (state_q == ST_DECIDE && res_d.gp_fault),
      .count_o (gp_count)
   );

   assign redir_bit = redir_word[vec[4:0]];
   assign perm_bit  = (port[15:10] != '0) ? 1'b1 : perm_word[port[4:0]];

   assign sensitive = op inside {OP_CLI, OP_STI, OP_PUSH_FLAGS_INSTR, OP_POP_FLAGS_INSTR,
                                 OP_SWINT, OP_INTERRUPT_RETURN_INSTR};  // see RULE4
   assign port_op   = op inside {OP_IN, OP_INS, OP_OUT, OP_STRING_OUTPUT_INSTR}; // see RULE5
   assign sw_int    = op == OP_SWINT;

   // Dispatch and fault decision
   always_comb begin
      res_d = '0;
      sel_word = '0;
      if (!flags_q[LM_BIT]) begin
         res_d.method = DSP_NONE;
      end else if (op == OP_PAGE) begin
         res_d.pg_fault = !pg_present;                  // see RULE8
      end else if (port_op) begin
         res_d.gp_fault = perm_bit;                     // see RULE7
      end else if (op == OP_HWINT || op == OP_EXC) begin
         res_d.to_prot = 1'b1;                          // see RULE13
         res_d.method  = mee ? DSP_M4 : DSP_M1;
      end else if (sw_int) begin
         // Six methods; map bit is ignored with the extension off
         if (!mee) begin                                // see RULE14
            res_d.method = (io_privilege_level == IO_PRIVILEGE_LEVEL_MAX) ? DSP_M1 : DSP_M2;
         end else begin
            case ({io_privilege_level == IO_PRIVILEGE_LEVEL_MAX, redir_bit})        // see RULE16
               2'b01:   res_d.method = DSP_M3;
               2'b11:   res_d.method = DSP_M4;          // see RULE17
               2'b10:   res_d.method = DSP_M5;          // see RULE15
               2'b00:   res_d.method = DSP_M6;
               default: res_d.method = DSP_NONE;
            endcase
         end
         res_d.gp_fault = res_d.method inside {DSP_M2, DSP_M3};
         res_d.to_prot  = res_d.method inside {DSP_M1, DSP_M4};
         res_d.redirect = res_d.method inside {DSP_M5, DSP_M6};
      end else if (sensitive) begin
         res_d.gp_fault = io_privilege_level != IO_PRIVILEGE_LEVEL_MAX;             // see RULE6
      end
      if (res_d.gp_fault || res_d.pg_fault) begin
         res_d.to_prot = 1'b1;                          // see RULE9
      end
      res_d.left_mode = res_d.to_prot;                  // see RULE1
      sel_word = flags_q;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         busy_q  <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  state_q <= ST_LOOKUP;
                  busy_q  <= 1'b1;
               end
            end
            ST_LOOKUP: state_q <= ST_DECIDE;
            ST_DECIDE: begin
               state_q <= ST_IDLE;
               busy_q  <= 1'b0;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         req_q   <= '0;
         ctrl_q  <= CTRL_RST;
         iomap_q <= '0;
      end else begin
         if (start) begin
            req_q <= apb_i.pwdata;
         end
         if (wr_acc && apb_i.paddr == ADDR_CTRL) begin
            ctrl_q <= apb_i.pwdata;
         end
         if (wr_acc && apb_i.paddr == ADDR_IOMAP) begin
            iomap_q <= apb_i.pwdata[15:0];
         end
      end
   end

   // Flags: task switch reload, and changes from dispatch
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         flags_q <= FLAGS_RST;
      end else if (wr_acc && apb_i.paddr == ADDR_FLAGS) begin
         flags_q <= apb_i.pwdata;
      end else if (wr_acc && apb_i.paddr == ADDR_TASKSW) begin
         flags_q <= apb_i.pwdata;                       // see RULE2
         if (!apb_i.pwdata[31] || !apb_i.pwdata[LM_BIT]) begin
            flags_q[LM_BIT] <= 1'b0;                    // see RULE3
         end
         flags_q[31] <= 1'b0;
      end else if (state_q == ST_DECIDE && !res_d.gp_fault
                   && res_d.to_prot) begin
         flags_q[LM_BIT] <= 1'b0;                       // see RULE19
         flags_q[TF_BIT] <= 1'b0;
      end else if (state_q == ST_DECIDE && res_d.redirect) begin
         flags_q[TF_BIT] <= 1'b0;                       // see RULE20
         flags_q[IF_BIT] <= 1'b0;
      end
   end

   // Outputs of a decision; general protection faults leave flags untouched
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         result_q     <= '0;
         push_flags_q <= '0;
         code_ptr_q   <= '0;
         seg_clear_q  <= 1'b0;
         cpl_q        <= CPL_PRIV;
      end else begin
         seg_clear_q <= 1'b0;
         if (state_q == ST_DECIDE) begin
            result_q <= res_d;
            if (res_d.gp_fault) begin
               push_flags_q <= sel_word;                // see RULE21
               code_ptr_q   <= '0;
            end else if (res_d.redirect) begin
               push_flags_q <= {16'h0000, sel_word[15] , 1'b0,
                                2'b00, sel_word[11:9], 1'b0,
                                sel_word[7:0]};
               code_ptr_q   <= VEC_TABLE + {22'h00_0000, vec, 2'b00};
            end else begin
               push_flags_q <= sel_word;
               code_ptr_q   <= {24'h00_0000, vec};
               seg_clear_q  <= res_d.to_prot;
            end
         end
         cpl_q <= flags_q[LM_BIT] ? CPL_LEGACY : CPL_PRIV;
      end
   end

   // APB slave: zero wait states, error on read of unmapped address
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rsp_q <= '0;
      end else begin
         rsp_q.pready  <= apb_i.psel && !apb_i.penable;
         rsp_q.pslverr <= 1'b0;
         rsp_q.prdata  <= '0;
         if (apb_i.psel && !apb_i.penable && !apb_i.pwrite) begin
            case (apb_i.paddr)
               ADDR_CTRL:   rsp_q.prdata <= ctrl_q;
               ADDR_FLAGS:  rsp_q.prdata <= flags_q;
               ADDR_REQ:    rsp_q.prdata <= req_q;
               ADDR_RESULT: rsp_q.prdata <= {24'h00_0000, result_q};
               ADDR_STATUS: rsp_q.prdata <= {gp_count, 15'h0000, busy_q};
               ADDR_IOMAP:  rsp_q.prdata <= {16'h0000, iomap_q};
               ADDR_TASKSW: rsp_q.prdata <= '0;
               default: begin
                  if (apb_i.paddr < ADDR_REDIR ||
                      apb_i.paddr >= ADDR_PERM + 4 * PERM_WORDS) begin
                     rsp_q.pslverr <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   assign apb_o = rsp_q;
   assign legacy_mode_o = flags_q[LM_BIT];
   assign cpl_o = cpl_q;
   assign result_o = result_q;
   assign flags_o = flags_q;
   assign push_flags_o = push_flags_q;
   assign code_ptr_o = code_ptr_q;
   assign seg_clear_o = seg_clear_q;

   a_gp_low_io_privilege_level: assert property ( // see RULE6
      @(posedge mclk_i) disable iff (rst_i)
      state_q == ST_DECIDE && flags_q[LM_BIT] && sensitive && op != OP_SWINT
      && io_privilege_level != IO_PRIVILEGE_LEVEL_MAX |=> result_q.gp_fault)
      else $error("sensitive op with low privilege did not fault");
   a_port_no_io_privilege_level: assert property ( // see RULE7
      @(posedge mclk_i) disable iff (rst_i)
      state_q == ST_DECIDE && flags_q[LM_BIT] && port_op
      |=> result_q.gp_fault == $past(perm_bit))
      else $error("port fault not from permission map");
   a_hw_prot: assert property ( // see RULE13
      @(posedge mclk_i) disable iff (rst_i)
      state_q == ST_DECIDE && flags_q[LM_BIT] && op == OP_HWINT
      |=> result_q.to_prot && !result_q.redirect)
      else $error("hardware interrupt not sent to protected handler");
   a_no_redir_off: assert property ( // see RULE14
      @(posedge mclk_i) disable iff (rst_i)
      state_q == ST_DECIDE && !mee |=> !result_q.redirect)
      else $error("redirect with extension off");
   a_m5_redirect: assert property ( // see RULE17
      @(posedge mclk_i) disable iff (rst_i)
      state_q == ST_DECIDE && flags_q[LM_BIT] && sw_int && mee
      && io_privilege_level == IO_PRIVILEGE_LEVEL_MAX && !redir_bit |=> result_q.method == DSP_M5)
      else $error("method five not chosen");
   a_page_fault: assert property ( // see RULE8
      @(posedge mclk_i) disable iff (rst_i)
      state_q == ST_DECIDE && flags_q[LM_BIT] && op == OP_PAGE
      && !pg_present |=> result_q.pg_fault)
      else $error("absent page did not fault");
   a_leave_mode: assert property ( // see RULE19
      @(posedge mclk_i) disable iff (rst_i)
      state_q == ST_DECIDE && res_d.to_prot && !res_d.gp_fault
      |=> !flags_q[LM_BIT] && !flags_q[TF_BIT])
      else $error("mode flag not cleared on protected entry");
   a_gp_no_change: assert property ( // see RULE21
      @(posedge mclk_i) disable iff (rst_i)
      state_q == ST_DECIDE && res_d.gp_fault && !wr_acc
      |=> $stable(flags_q))
      else $error("fault changed flags");
   a_cpl_three: assert property ( // see RULE6
      @(posedge mclk_i) disable iff (rst_i)
      flags_q[LM_BIT] |=> cpl_q == CPL_LEGACY)
      else $error("privilege not 3 in legacy mode");

   c_redirect: cover property (@(posedge mclk_i) result_q.redirect);
   c_gp: cover property (@(posedge mclk_i) result_q.gp_fault);
   c_prot: cover property (@(posedge mclk_i) result_q.to_prot);
endmodule
`default_nettype wire

/* File: hdl/vm_ctrl_pkg.sv */
// Package: constants and carriers for the legacy VM mode control block
`default_nettype none
package vm_ctrl_pkg;
   localparam int unsigned ADDR_CTRL     = 32'h0000_0000;
   localparam int unsigned ADDR_FLAGS    = 32'h0000_0004;
   localparam int unsigned ADDR_REQ      = 32'h0000_0008;
   localparam int unsigned ADDR_RESULT   = 32'h0000_000C;
   localparam int unsigned ADDR_STATUS   = 32'h0000_0010;
   localparam int unsigned ADDR_IOMAP    = 32'h0000_0014;
   localparam int unsigned ADDR_REDIR    = 32'h0000_0020;
   localparam int unsigned ADDR_PERM     = 32'h0000_0040;
   localparam int unsigned ADDR_TASKSW   = 32'h0000_0018;
   localparam int unsigned REDIR_WORDS   = 8;
   localparam int unsigned PERM_WORDS    = 32;
   localparam int unsigned MEE_BIT       = 0;
   localparam int unsigned TF_BIT        = 8;
   localparam int unsigned IF_BIT        = 9;
   localparam int unsigned IO_PRIVILEGE_LEVEL_LO       = 12;
   localparam int unsigned NT_BIT        = 14;
   localparam int unsigned LM_BIT        = 17;
   localparam logic [1:0] IO_PRIVILEGE_LEVEL_MAX      = 2'h3;
   localparam logic [1:0] CPL_LEGACY    = 2'h3;
   localparam logic [1:0] CPL_PRIV      = 2'h0;
   localparam logic [31:0] FLAGS_RST    = 32'h0000_0002;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [15:0] REDIR_BYTES  = 16'h0020;
   localparam logic [31:0] VEC_TABLE    = 32'h0000_0000;

   typedef enum logic [3:0] {
      OP_NONE, OP_CLI, OP_STI, OP_PUSH_FLAGS_INSTR, OP_POP_FLAGS_INSTR, OP_SWINT, OP_INTERRUPT_RETURN_INSTR,
      OP_IN, OP_INS, OP_OUT, OP_STRING_OUTPUT_INSTR, OP_HWINT, OP_EXC, OP_PAGE
   } op_type;

   typedef enum logic [2:0] {
      DSP_NONE, DSP_M1, DSP_M2, DSP_M3, DSP_M4, DSP_M5, DSP_M6
   } method_type;

   typedef struct packed {
      logic        gp_fault;
      logic        pg_fault;
      logic        to_prot;
      logic        redirect;
      logic        left_mode;
      method_type  method;
   } result_type;

   typedef struct packed {
      logic [31:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_type;
endpackage
`default_nettype wire

/* File: hdl/vm_bitmap_mem.sv */
// Word memory for a bit map, with registered read data
`default_nettype none
module vm_bitmap_mem #(
   parameter int unsigned WORDS = 8,
   parameter int unsigned AW    = 3
) (
   input  wire logic          mclk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [31:0]   wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [31:0]   rdata_o
);
   logic [31:0] mem_q [WORDS];

   always_ff @(posedge mclk_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      rdata_o <= mem_q[raddr_i];
   end
endmodule
`default_nettype wire

/* File: hdl/vm_event_cnt.sv */
// Saturating event counter
`default_nettype none
module vm_event_cnt #(
   parameter int unsigned W = 16
) (
   input  wire logic         mclk_i,
   input  wire logic         rst_i,
   input  wire logic         clr_i,
   input  wire logic         inc_i,
   output logic      [W-1:0] count_o
);
   always_ff @(posedge mclk_i) begin
      if (rst_i || clr_i) begin
         count_o <= '0;
      end else if (inc_i && count_o != '1) begin
         count_o <= count_o + 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the legacy VM mode control block
`default_nettype none
`define CHK(nm, e, g) begin \
   checked++; \
   if ((g) !== (e)) begin \
      err_count++; \
      $display("wrong value %s exp %0h got %0h", nm, e, g); \
   end \
end
module testbench import vm_ctrl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk_i = 1'b0;
   logic        rst_i  = 1'b1;
   apb_req_type apb_q  = '0;
   apb_rsp_type apb_r;
   logic        legacy;
   logic [1:0]  current_privilege_level;
   result_type  res;
   logic [31:0] flags;
   logic [31:0] push_flags_instr;
   logic [31:0] cptr;
   logic        segclr;
   int          err_count = 0;
   int          checked = 0;
   int          cycles = 0;
   int          seg_cnt = 0;
   logic [31:0] lfsr_q = 32'h0000_003B;
   logic [31:0] redir [8];

   legacy_vm_mode_control dut_u (
      .mclk_i(mclk_i), .rst_i(rst_i), .apb_i(apb_q), .apb_o(apb_r),
      .legacy_mode_o(legacy), .cpl_o(current_privilege_level), .result_o(res),
      .flags_o(flags), .push_flags_o(push_flags_instr), .code_ptr_o(cptr),
      .seg_clear_o(segclr));

   always #2 mclk_i = ~mclk_i;

   function automatic logic [31:0] rnd();
      lfsr_q = {lfsr_q[30:0],
                lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q;
   endfunction

   // Dispatch method from extension enable, privilege field and map bit
   function automatic method_type exp_m(input logic v, input logic [1:0] pl,
                                        input logic b);
      if (!v) return (pl == IO_PRIVILEGE_LEVEL_MAX) ? DSP_M1 : DSP_M2;
      if (b) return (pl == IO_PRIVILEGE_LEVEL_MAX) ? DSP_M4 : DSP_M3;
      return (pl == IO_PRIVILEGE_LEVEL_MAX) ? DSP_M5 : DSP_M6;
   endfunction

   task automatic results();
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   always @(posedge mclk_i) begin
      cycles++;
      // Segment clear is a one-cycle pulse, so count it as it passes
      if (segclr === 1'b1) begin
         seg_cnt++;
      end
      if (cycles == 30000) begin
         err_count++;
         results();
      end
   end

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input  logic        wr,
                      input  logic [31:0] a,
                      input  logic [31:0] wd,
                      output logic [31:0] d,
                      output logic        e);
      apb_q.paddr <= a;
      apb_q.pwrite <= wr;
      apb_q.pwdata <= wd;
      apb_q.psel <= 1'b1;
      @(posedge mclk_i);
      apb_q.penable <= 1'b1;
      @(posedge mclk_i);
      while (apb_r.pready !== 1'b1) begin
         @(posedge mclk_i);
      end
      d = apb_r.prdata;
      e = apb_r.pslverr;
      apb_q.psel <= 1'b0;
      apb_q.penable <= 1'b0;
      @(posedge mclk_i);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic        e;
      apb(1'b1, a, d, x, e);
   endtask

   // Task switch in with a 32-bit image, mode flag set
   task automatic enter(input logic [1:0] pl, input logic mode_extension_enable);
      wr(ADDR_CTRL, {31'h0, mode_extension_enable});
      wr(ADDR_TASKSW, 32'h8000_4000 | (32'h1 << LM_BIT) | ({30'h0, pl} << 12));
      repeat (2) @(posedge mclk_i);
   endtask

   task automatic req(input op_type op, input logic [7:0] vec,
                      input logic [15:0] port, input logic pres);
      logic [31:0] s;
      logic        e;
      s = 32'h1;
      apb(1'b1, ADDR_REQ, {port, vec, 3'b000, pres, op}, s, e);
      s = 32'h1;
      while (s[0] !== 1'b0) begin
         apb(1'b0, ADDR_STATUS, 32'h0, s, e);
      end
   endtask

   initial begin
      logic [31:0] r;
      logic [31:0] f;
      logic        e;
      logic        b;
      logic [7:0]  v;
      method_type  m;
      int          s0;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      `CHK("mode after reset", 1'b0, legacy)
      apb(1'b0, 32'h0000_0100, 32'h0, r, e);
      `CHK("unmapped error", 1'b1, e)
      $display("test reset done");
      // Images: 32-bit mode set, 32-bit mode clear, 16-bit mode set
      for (int i = 0; i < 3; i++) begin
         r = (i == 1) ? 32'h8000_0000 : 32'h0000_0000 | (32'h1 << LM_BIT);
         if (i == 0) r = r | 32'h8000_0000;
         wr(ADDR_TASKSW, r | 32'h0000_3000);
         repeat (2) @(posedge mclk_i);
         `CHK("mode flag", (i == 0), legacy)
         `CHK("privilege", (i == 0) ? CPL_LEGACY : CPL_PRIV, current_privilege_level)
         `CHK("io privilege", 2'h3, flags[13:12])
      end
      $display("test task switch done");
      wr(ADDR_STATUS, 32'h0);
      for (int o = 1; o <= 6; o++) begin
         for (int pl = 0; pl < 4; pl++) begin
            enter(pl[1:0], 1'b0);
            f = flags;
            r = rnd();
            req(op_type'(o), r[7:0], 16'h0, 1'b1);
            `CHK("sensitive fault", (pl != 3), res.gp_fault)
            if (pl != 3) `CHK("flags kept", f, flags)
         end
      end
      apb(1'b0, ADDR_STATUS, 32'h0, r, e);
      `CHK("fault count", 16'h0012, r[31:16])
      $display("test sensitive done");
      for (int o = 7; o <= 10; o++) begin
         for (int k = 0; k < 3; k++) begin
            r = rnd();
            b = r[20];
            enter(2'h0, 1'b0);
            wr(ADDR_PERM + 4 * r[9:5], {31'h0, b} << r[4:0]);
            req(op_type'(o), 8'h0, {6'h0, r[9:0]}, 1'b1);
            `CHK("port fault", b, res.gp_fault)
         end
      end
      $display("test port io done");
      for (int p = 0; p < 2; p++) begin
         enter(2'h3, 1'b0);
         req(OP_PAGE, 8'h0, 16'h0, p[0]);
         `CHK("page fault", !p[0], res.pg_fault)
      end
      $display("test page done");
      for (int i = 0; i < 8; i++) begin
         redir[i] = rnd();
         wr(ADDR_REDIR + 4 * i, redir[i]);
      end
      for (int k = 0; k < 24; k++) begin
         r = rnd();
         v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : r[7:0];
         b = redir[v[7:5]][v[4:0]];
         m = exp_m(r[10], r[12:11], b);
         enter(r[12:11], r[10]);
         s0 = seg_cnt;
         req(OP_SWINT, v, 16'h0, 1'b1);
         `CHK("method", m, res.method)
         b = (m == DSP_M1 || m == DSP_M4);
         `CHK("segments cleared", b, seg_cnt - s0)
         apb(1'b0, ADDR_RESULT, 32'h0, r, e);
         `CHK("result method", m, r[2:0])
         if (m == DSP_M5) begin
            `CHK("redirect", 1'b1, res.redirect)
            `CHK("vector ptr", {22'h0, v, 2'b00}, cptr)
            `CHK("pushed fields", 3'b000, push_flags_instr[14:12])
         end
         if (m == DSP_M1 || m == DSP_M4) begin
            `CHK("to protected", 1'b1, res.to_prot)
            `CHK("left mode", 1'b1, res.left_mode)
            `CHK("mode cleared", 1'b0, legacy)
         end
      end
      $display("test dispatch done");
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         enter(2'h3, 1'b1);
         s0 = seg_cnt;
         req((k < 2) ? OP_HWINT : OP_EXC, r[7:0], 16'h0, 1'b1);
         `CHK("hw segments cleared", 1, seg_cnt - s0)
         `CHK("hw to protected", 1'b1, res.to_prot)
         `CHK("hw no redirect", 1'b0, res.redirect)
      end
      $display("test hardware done");
      results();
   end
endmodule
`undef CHK
`default_nettype wire
